// ===== hw/spicsp_pkg.sv
package spicsp_pkg;
  // CPU clock and the half-period unit H in which every bit clock relation is counted.
  localparam int CPU_CLK_MHZ = 25;
  localparam int CPU_CLK_PS = 1000000 / CPU_CLK_MHZ;
  localparam int H_PS = CPU_CLK_PS / 2;
  localparam int CYC_PER_2H = (2 * H_PS) / CPU_CLK_PS;

  localparam int WORD_BITS = 8;
  localparam logic [4:0] EDGES_PER_WORD = 5'h10;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRG = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_TX_CLOCK_DIRECTION = 1;
  localparam int CTRL_RX_CLOCK_DIRECTION = 2;
  localparam int CTRL_TX_FRAME_DIRECTION = 3;
  localparam int CTRL_RX_FRAME_DIRECTION = 4;
  localparam int CTRL_CLOCK_STOP_LSB = 5;
  localparam int CTRL_TX_CLOCK_POLARITY = 7;
  localparam int CTRL_RX_FRAME_POLARITY = 8;
  localparam int CTRL_TX_FRAME_POLARITY = 9;
  localparam int CTRL_WIDTH = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  localparam int SRG_CLOCK_SOURCE_SELECT = 8;
  localparam int SRG_WIDTH = 9;
  localparam logic [8:0] SRG_RESET = 9'h101;
  localparam logic [7:0] SLAVE_DIVIDE_VALUE = 8'h01;

  localparam logic [1:0] CLOCK_STOP_NO_DELAY = 2'h2;
  localparam logic [1:0] CLOCK_STOP_HALF_DELAY = 2'h3;

  localparam int STAT_BUSY = 0;
  localparam int STAT_TX_PENDING = 1;
  localparam int STAT_RX_FULL = 2;
  localparam int STAT_CONFIG_ERROR = 3;
  localparam int STAT_OVERRUN = 4;

  typedef enum logic [1:0] {
    SPICSP_IDLE = 2'b00,
    SPICSP_LEAD = 2'b01,
    SPICSP_SHIFT = 2'b11,
    SPICSP_TRAIL = 2'b10
  } spicsp_state_t;
endpackage

// ===== hw/spicsp_top.sv
// What this block does
// - Phase timing is counted in H, half a CPU clock; 2H is one cycle.
// - As master the bit clock period is one plus divide value CPU cycles, a zero divide counting as one.
// - Low phase is half period for odd or zero divide, divide/2 when even.
// - High phase is half period for odd or zero divide, divide/2+1 when even.
// - Master drives slave-enable as internal frame XOR polarity, active low with polarity one.
// - As slave the select inputs are inverted by polarity before internal use.
// - Master needs transmit clock and frame outputs, receive clock and frame inputs.
// - Slave needs every clock and frame direction set to input.
// - Slave works only with generated clock at half CPU clock, source and divide one.
// - Slave-enable goes active before the first bit clock edge of a transfer.
// - Four variants: clock-stop 10b or 11b with transmit clock polarity 0 or 1.
// - Stop 10b polarity 1 samples on the high edge, launches on the low edge.
// - Stop 11b polarity 1 samples on the low edge, launches on the high edge.
// - Stop 11b polarity 0 asserts slave-enable one period before the first rising edge.
// - Stop 11b polarity 0 holds slave-enable one low phase after the last falling edge.
// - As slave the data output is released once slave-enable goes inactive, which is high with polarity one and low with polarity zero.
module spicsp_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_bit_clock_i,
  output logic spi_bit_clock_o,
  output logic spi_bit_clock_oe,
  input wire logic slave_enable_tx_pin_i,
  output logic slave_enable_tx_pin_o,
  output logic slave_enable_tx_pin_oe,
  input wire logic frame_sync_rx_pin_i,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe
);
  typedef struct packed {
    spicsp_pkg::spicsp_state_t state;
    logic [spicsp_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [spicsp_pkg::SRG_WIDTH-1:0] srg;
    logic [7:0] tx_buf;
    logic tx_pending;
    logic [7:0] rx_data;
    logic rx_full;
    logic overrun;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [3:0] bits;
    logic [4:0] edges;
    logic [8:0] cnt;
    logic clk;
    logic fs;
    logic clk_prev;
    logic slave_act;
    logic [31:0] prdata;
  } spicsp_regs_t;

  spicsp_regs_t st_r;
  spicsp_regs_t st_nxt;

  logic enable;
  logic tx_clk_dir;
  logic rx_clk_dir;
  logic tx_fs_dir;
  logic rx_fs_dir;
  logic [1:0] clk_stop;
  logic clk_pol;
  logic rx_fs_pol;
  logic tx_fs_pol;
  logic [7:0] div_raw;
  logic [7:0] div_eff;
  logic master_mode;
  logic slave_mode;
  logic stop_valid;
  logic slave_cfg_ok;
  logic config_error;
  logic [8:0] per_len;
  logic [8:0] low_len;
  logic [8:0] high_len;
  logic [8:0] idle_len;
  logic [8:0] lead_len;
  logic [8:0] trail_len;
  logic sample_on_rise;
  logic slave_sel;
  logic slave_rx_sel;
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign enable = st_r.ctrl[spicsp_pkg::CTRL_ENABLE];
  assign tx_clk_dir = st_r.ctrl[spicsp_pkg::CTRL_TX_CLOCK_DIRECTION];
  assign rx_clk_dir = st_r.ctrl[spicsp_pkg::CTRL_RX_CLOCK_DIRECTION];
  assign tx_fs_dir = st_r.ctrl[spicsp_pkg::CTRL_TX_FRAME_DIRECTION];
  assign rx_fs_dir = st_r.ctrl[spicsp_pkg::CTRL_RX_FRAME_DIRECTION];
  assign clk_stop = st_r.ctrl[spicsp_pkg::CTRL_CLOCK_STOP_LSB +: 2];
  assign clk_pol = st_r.ctrl[spicsp_pkg::CTRL_TX_CLOCK_POLARITY];
  assign rx_fs_pol = st_r.ctrl[spicsp_pkg::CTRL_RX_FRAME_POLARITY];
  assign tx_fs_pol = st_r.ctrl[spicsp_pkg::CTRL_TX_FRAME_POLARITY];
  assign div_raw = st_r.srg[7:0];

  assign stop_valid = (clk_stop == spicsp_pkg::CLOCK_STOP_NO_DELAY) ||
                      (clk_stop == spicsp_pkg::CLOCK_STOP_HALF_DELAY);
  assign master_mode = tx_clk_dir && tx_fs_dir && !rx_clk_dir && !rx_fs_dir;
  assign slave_mode = !tx_clk_dir && !tx_fs_dir && !rx_clk_dir && !rx_fs_dir;
  assign slave_cfg_ok = st_r.srg[spicsp_pkg::SRG_CLOCK_SOURCE_SELECT] &&
                        (div_raw == spicsp_pkg::SLAVE_DIVIDE_VALUE);
  assign config_error = enable && (!stop_valid || !(master_mode || (slave_mode && slave_cfg_ok)));

  // A half-cycle phase cannot be made from ref_clk, so a zero divide runs as divide one.
  assign div_eff = (div_raw == 8'h00) ? 8'h01 : div_raw;
  assign per_len = 9'({1'b0, div_eff} + 9'h001) * 9'(spicsp_pkg::CYC_PER_2H);
  assign low_len = 9'({1'b0, div_eff[7:1]} + {8'h00, div_eff[0]});
  assign high_len = per_len - low_len;
  assign idle_len = clk_pol ? high_len : low_len;
  // Half-delay mode leads by a full period and trails by the idle phase; no-delay the reverse.
  assign lead_len = (clk_stop == spicsp_pkg::CLOCK_STOP_HALF_DELAY) ? per_len : idle_len;
  assign trail_len = (clk_stop == spicsp_pkg::CLOCK_STOP_HALF_DELAY) ? idle_len : per_len;
  assign sample_on_rise = (clk_stop == spicsp_pkg::CLOCK_STOP_HALF_DELAY) ? !clk_pol : clk_pol;

  assign slave_sel = slave_enable_tx_pin_i ^ tx_fs_pol;
  assign slave_rx_sel = frame_sync_rx_pin_i ^ rx_fs_pol;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped = (paddr == spicsp_pkg::ADDR_CTRL) || (paddr == spicsp_pkg::ADDR_SRG) ||
                  (paddr == spicsp_pkg::ADDR_TXDATA) || (paddr == spicsp_pkg::ADDR_RXDATA) ||
                  (paddr == spicsp_pkg::ADDR_STATUS);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[spicsp_pkg::STAT_BUSY] = (st_r.state != spicsp_pkg::SPICSP_IDLE);
    status_word[spicsp_pkg::STAT_TX_PENDING] = st_r.tx_pending;
    status_word[spicsp_pkg::STAT_RX_FULL] = st_r.rx_full;
    status_word[spicsp_pkg::STAT_CONFIG_ERROR] = config_error;
    status_word[spicsp_pkg::STAT_OVERRUN] = st_r.overrun;
    case (paddr)
      spicsp_pkg::ADDR_CTRL: rd_word = {22'h000000, st_r.ctrl};
      spicsp_pkg::ADDR_SRG: rd_word = {23'h000000, st_r.srg};
      spicsp_pkg::ADDR_TXDATA: rd_word = {24'h000000, st_r.tx_buf};
      spicsp_pkg::ADDR_RXDATA: rd_word = {24'h000000, st_r.rx_data};
      spicsp_pkg::ADDR_STATUS: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic edge_now;
    logic new_clk;
    logic word_done;
    logic rx_clear;
    logic tx_load;
    edge_now = 1'b0;
    tx_load = 1'b0;
    new_clk = st_r.clk;
    word_done = 1'b0;
    rx_clear = 1'b0;
    st_nxt = st_r;
    st_nxt.clk_prev = spi_bit_clock_i;

    if (setup_ph) begin
      st_nxt.prdata = rd_word;
    end
    if (access_ph && pwrite) begin
      case (paddr)
        spicsp_pkg::ADDR_CTRL: st_nxt.ctrl = pwdata[spicsp_pkg::CTRL_WIDTH-1:0];
        spicsp_pkg::ADDR_SRG: st_nxt.srg = pwdata[spicsp_pkg::SRG_WIDTH-1:0];
        spicsp_pkg::ADDR_TXDATA: begin
          st_nxt.tx_buf = pwdata[7:0];
          tx_load = 1'b1;
        end
        spicsp_pkg::ADDR_STATUS: begin
          if (pwdata[spicsp_pkg::STAT_OVERRUN]) begin
            st_nxt.overrun = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (access_ph && !pwrite && (paddr == spicsp_pkg::ADDR_RXDATA)) begin
      rx_clear = 1'b1;
    end
    if (rx_clear) begin
      st_nxt.rx_full = 1'b0;
    end

    case (st_r.state)
      spicsp_pkg::SPICSP_IDLE: begin
        st_nxt.clk = clk_pol;
        st_nxt.fs = 1'b0;
        st_nxt.slave_act = 1'b0;
        if (enable && !config_error && master_mode && st_r.tx_pending) begin
          st_nxt.tx_sh = st_r.tx_buf;
          st_nxt.tx_pending = 1'b0;
          st_nxt.bits = 4'h0;
          st_nxt.edges = 5'h00;
          st_nxt.fs = 1'b1;
          st_nxt.cnt = lead_len - 9'h001;
          st_nxt.state = spicsp_pkg::SPICSP_LEAD;
        end else if (enable && !config_error && slave_mode && slave_sel) begin
          st_nxt.tx_sh = st_r.tx_pending ? st_r.tx_buf : 8'h00;
          st_nxt.tx_pending = 1'b0;
          st_nxt.bits = 4'h0;
          st_nxt.slave_act = 1'b1;
          st_nxt.state = spicsp_pkg::SPICSP_SHIFT;
        end
      end
      spicsp_pkg::SPICSP_LEAD, spicsp_pkg::SPICSP_SHIFT: begin
        if (st_r.slave_act) begin
          if (!slave_sel) begin
            word_done = (st_r.bits == spicsp_pkg::BITS_PER_WORD);
            st_nxt.slave_act = 1'b0;
            st_nxt.state = spicsp_pkg::SPICSP_IDLE;
          end else if (spi_bit_clock_i != st_r.clk_prev) begin
            edge_now = 1'b1;
            new_clk = spi_bit_clock_i;
          end
        end else if (st_r.cnt != 9'h000) begin
          st_nxt.cnt = st_r.cnt - 9'h001;
        end else begin
          edge_now = 1'b1;
          new_clk = !st_r.clk;
          st_nxt.clk = new_clk;
          st_nxt.edges = st_r.edges + 5'h01;
          st_nxt.state = spicsp_pkg::SPICSP_SHIFT;
          if (st_r.edges + 5'h01 == spicsp_pkg::EDGES_PER_WORD) begin
            st_nxt.cnt = trail_len - 9'h001;
            st_nxt.state = spicsp_pkg::SPICSP_TRAIL;
          end else begin
            st_nxt.cnt = (new_clk ? high_len : low_len) - 9'h001;
          end
        end
        if (edge_now) begin
          if (new_clk == sample_on_rise) begin
            if (!st_r.slave_act || slave_rx_sel) begin
              st_nxt.rx_sh = {st_r.rx_sh[6:0], serial_data_in};
              st_nxt.bits = st_r.bits + 4'h1;
            end
          end else if (st_r.bits != 4'h0) begin
            st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
          end
        end
      end
      spicsp_pkg::SPICSP_TRAIL: begin
        if (st_r.cnt != 9'h000) begin
          st_nxt.cnt = st_r.cnt - 9'h001;
        end else begin
          st_nxt.fs = 1'b0;
          word_done = 1'b1;
          st_nxt.state = spicsp_pkg::SPICSP_IDLE;
        end
      end
      default: st_nxt.state = spicsp_pkg::SPICSP_IDLE;
    endcase

    // A buffer write in the cycle that hands the old word to the shifter keeps the new word pending.
    if (tx_load) begin
      st_nxt.tx_pending = 1'b1;
    end

    // A word landing in the same cycle as the read that clears the flag keeps the flag set.
    if (word_done) begin
      if (st_r.rx_full && !rx_clear) begin
        st_nxt.overrun = 1'b1;
      end
      st_nxt.rx_data = st_r.rx_sh;
      st_nxt.rx_full = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{state: spicsp_pkg::SPICSP_IDLE, ctrl: spicsp_pkg::CTRL_RESET,
                srg: spicsp_pkg::SRG_RESET, tx_buf: 8'h00, tx_pending: 1'b0, rx_data: 8'h00,
                rx_full: 1'b0, overrun: 1'b0, tx_sh: 8'h00, rx_sh: 8'h00, bits: 4'h0,
                edges: 5'h00, cnt: 9'h000, clk: 1'b0, fs: 1'b0, clk_prev: 1'b0,
                slave_act: 1'b0, prdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = access_ph;
  assign pslverr = access_ph && !mapped;

  assign spi_bit_clock_o = st_r.clk;
  assign spi_bit_clock_oe = enable && tx_clk_dir;
  assign slave_enable_tx_pin_o = st_r.fs ^ tx_fs_pol;
  assign slave_enable_tx_pin_oe = enable && tx_fs_dir;
  assign serial_data_out = st_r.tx_sh[spicsp_pkg::WORD_BITS-1];
  assign serial_data_out_oe = st_r.fs || st_r.slave_act;
endmodule

// ===== dv/spicsp_asserts.sv
module spicsp_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic spi_bit_clock_o,
  input wire logic spi_bit_clock_oe,
  input wire logic slave_enable_tx_pin_i,
  input wire logic slave_enable_tx_pin_o,
  input wire logic slave_enable_tx_pin_oe,
  input wire logic serial_data_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [8:0] run_r;
  logic [8:0] prev_r;
  logic [4:0] edges_r;
  wire frame = slave_enable_tx_pin_oe && !slave_enable_tx_pin_o;
  // Length of the level that just ended and of the one before it.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 9'h001;
      prev_r <= 9'h000;
      edges_r <= 5'h00;
    end else if ($changed(spi_bit_clock_o)) begin
      run_r <= 9'h001;
      prev_r <= run_r;
      edges_r <= frame ? edges_r + 5'h01 : 5'h00;
    end else begin
      run_r <= run_r + 9'h001;
      edges_r <= frame ? edges_r : 5'h00;
    end
  end
  sequence slave_drop_s;
    !slave_enable_tx_pin_oe && $rose(slave_enable_tx_pin_i);
  endsequence
  sequence out_free_s;
    ##[1:3] !serial_data_out_oe;
  endsequence
  slverr_scope_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access");
  frame_lead_a: assert property ($fell(slave_enable_tx_pin_o) && slave_enable_tx_pin_oe |-> $stable(spi_bit_clock_o))
    else $error("bit clock moved as select fell");
  clock_idle_a: assert property (slave_enable_tx_pin_oe && slave_enable_tx_pin_o && $changed(spi_bit_clock_o)
    |-> $past(psel && penable && pwrite, 2)) else $error("bit clock ran outside a frame");
  low_phase_a: assert property ($rose(spi_bit_clock_o) && frame && edges_r >= 5'h02
    |-> run_r == prev_r || run_r + 9'h001 == prev_r) else $error("low phase length wrong");
  high_phase_a: assert property ($fell(spi_bit_clock_o) && frame && edges_r >= 5'h02
    |-> run_r == prev_r || run_r == prev_r + 9'h001) else $error("high phase length wrong");
  frame_data_a: assert property (frame |-> serial_data_out_oe)
    else $error("data not driven in frame");
  frame_clock_a: assert property (frame |-> spi_bit_clock_oe)
    else $error("bit clock not driven in frame");
  slave_release_a: assert property (slave_drop_s |-> out_free_s)
    else $error("data out not released");
endmodule

// ===== dv/spicsp_peer.sv
module spicsp_peer (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic rise_samp,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int n;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end
  always @(negedge sel_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
    n = 0;
  end
  // A released line shows the inverse of its last bit, never a held value.
  always @(posedge sel_n) miso = ~miso;
  always @(sclk) begin
    if (!sel_n && sclk === rise_samp) begin
      rx_byte = {rx_byte[6:0], mosi};
      n = n + 1;
    end else if (!sel_n && n > 0 && n < 8) begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule

// ===== dv/spicsp_tb_top.sv
module spicsp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, arst_n, psel, penable, pwrite, clk_i, sel_i, fr_i, tb_din, slv, rise_samp, miso, last_err;
  logic pready, pslverr, clk_o, clk_oe, sel_o, sel_oe, dout, dout_oe;
  logic [7:0] paddr, peer_tx, peer_rx, tx, sb;
  logic [31:0] pwdata, prdata, r;
  int errors = 0;
  int checks_done = 0;
  int n, t;
  int divs [4] = '{3, 4, 0, 2};
  spicsp_top u_spicsp_top (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .spi_bit_clock_i(clk_i), .spi_bit_clock_o(clk_o), .spi_bit_clock_oe(clk_oe),
    .slave_enable_tx_pin_i(sel_i), .slave_enable_tx_pin_o(sel_o), .slave_enable_tx_pin_oe(sel_oe),
    .frame_sync_rx_pin_i(fr_i), .serial_data_in(slv ? tb_din : miso), .serial_data_out(dout),
    .serial_data_out_oe(dout_oe));
  spicsp_peer u_spicsp_peer (.sclk(clk_o), .sel_n(sel_o), .mosi(dout), .rise_samp, .tx_byte(peer_tx),
    .miso, .rx_byte(peer_rx));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    print_verdict;
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clk_i = 1'b0;
    sel_i = 1'b1;
    fr_i = 1'b1;
    tb_din = 1'b0;
    slv = 1'b0;
    rise_samp = 1'b0;
    peer_tx = 8'h00;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(spicsp_pkg::ADDR_CTRL, 32'h0);
    rd(spicsp_pkg::ADDR_SRG, 32'h101);
    rd(8'h14, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    // A clock-stop field of 00 is not one of the supported variants.
    apb(1'b1, spicsp_pkg::ADDR_CTRL, 32'h30b);
    rd(spicsp_pkg::ADDR_STATUS, 32'h8);
    for (int m = 0; m < 4; m++) begin
      t = (divs[m] == 0 ? 1 : divs[m]) + 1;
      rise_samp <= (m == 1) || (m == 2);
      peer_tx <= 8'h96 ^ m[7:0];
      tx = 8'h5c + 8'(m);
      apb(1'b1, spicsp_pkg::ADDR_SRG, 32'h100 | divs[m]);
      apb(1'b1, spicsp_pkg::ADDR_CTRL, 32'h30b | ((2 + m / 2) << 5) | ((m % 2) << 7));
      apb(1'b1, spicsp_pkg::ADDR_TXDATA, {24'h0, tx});
      n = 0;
      while (sel_o !== 1'b0) @(posedge ref_clk);
      while (sel_o === 1'b0) begin
        n++;
        @(posedge ref_clk);
      end
      chk(n, 9 * t);
      chk({24'h0, peer_rx}, {24'h0, tx});
      rd(spicsp_pkg::ADDR_RXDATA, {24'h0, 8'h96 ^ m[7:0]});
    end
    // A second word that lands before the first is read raises overrun; writing one to its bit clears it.
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, spicsp_pkg::ADDR_TXDATA, 32'h11);
      rd(spicsp_pkg::ADDR_STATUS, 32'h1 | (k << 2));
      while (sel_o !== 1'b0) @(posedge ref_clk);
      while (sel_o === 1'b0) @(posedge ref_clk);
      chk({24'h0, peer_rx}, 32'h11);
    end
    rd(spicsp_pkg::ADDR_STATUS, 32'h14);
    apb(1'b1, spicsp_pkg::ADDR_STATUS, 32'h10);
    rd(spicsp_pkg::ADDR_STATUS, 32'h4);
    rd(spicsp_pkg::ADDR_RXDATA, 32'h95);
    rd(spicsp_pkg::ADDR_STATUS, 32'h0);
    slv <= 1'b1;
    apb(1'b1, spicsp_pkg::ADDR_SRG, 32'h101);
    apb(1'b1, spicsp_pkg::ADDR_CTRL, 32'h361);
    apb(1'b1, spicsp_pkg::ADDR_TXDATA, 32'ha7);
    tx = 8'h3d;
    sb = 8'h00;
    sel_i <= 1'b0;
    fr_i <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tb_din <= tx[i];
      repeat (4) @(posedge ref_clk);
      sb = {sb[6:0], dout};
      clk_i <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clk_i <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    sel_i <= 1'b1;
    fr_i <= 1'b1;
    tb_din <= ~tb_din;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, dout_oe}, 32'h0);
    chk({24'h0, sb}, 32'ha7);
    rd(spicsp_pkg::ADDR_RXDATA, 32'h3d);
    print_verdict;
  end
endmodule

bind spicsp_top spicsp_asserts u_spicsp_asserts (.ref_clk, .arst_n, .psel, .penable, .pwrite, .pslverr,
  .spi_bit_clock_o, .spi_bit_clock_oe, .slave_enable_tx_pin_i, .slave_enable_tx_pin_o,
  .slave_enable_tx_pin_oe, .serial_data_out_oe);
